// file: pkg/synth_regs_pkg.sv
// shared constants, field layouts and config structs of the synthesizer register slice
package synth_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned CAL_TIME_NS   = 1000;
    localparam int unsigned CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CAL_CNT_W     = $clog2(CAL_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [9:0]  IDX_FILTER_CAP_C1   = 10'h044;
    localparam logic [9:0]  IDX_FILTER_RES_R3   = 10'h045;
    localparam logic [9:0]  IDX_FILTER_CAP_C3   = 10'h046;
    localparam logic [9:0]  IDX_SYNTH2_CONTROL  = 10'h047;
    localparam logic [9:0]  IDX_SYNTH2_STATUS   = 10'h048;
    localparam int unsigned ADDR_W              = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned CAP_ONE_LSB    = 0;
    localparam int unsigned CAP_THREE_LSB  = 0;
    localparam int unsigned RES_THREE_LSB  = 1;
    localparam int unsigned TYPE_SEL_BIT   = 0;
    localparam int unsigned POST_DIV_LSB   = 2;
    localparam int unsigned REALIGN_EN_BIT = 1;
    localparam int unsigned POWER_DOWN_BIT = 0;
    localparam int unsigned ST_ENABLE_BIT  = 0;
    localparam int unsigned ST_BUSY_BIT    = 1;
    localparam int unsigned ST_DONE_BIT    = 2;
    localparam int unsigned ST_COUNT_LSB   = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [2:0] RST_CAP_ONE    = 3'h0;
    localparam logic [5:0] RST_RES_THREE  = 6'h00;
    localparam logic       RST_TYPE_SEL   = 1'b0;
    localparam logic [2:0] RST_CAP_THREE  = 3'h0;
    localparam logic [2:0] RST_POST_DIV   = 3'h7;
    localparam logic       RST_REALIGN_EN = 1'b1;
    localparam logic       RST_POWER_DOWN = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // analog scaling of capacitor codes, in pF
    localparam logic [8:0] CAP_ONE_BASE_PF  = 9'h005;
    localparam logic [8:0] CAP_ONE_STEP_PF  = 9'h032;
    localparam logic [5:0] CAP_THREE_STEP_PF = 6'h05;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration carriers
    typedef struct packed {
        logic       first_filter_type_select;
        logic [5:0] first_filter_res_three_code;
        logic [2:0] first_filter_cap_one_code;
        logic [2:0] first_filter_cap_three_code;
    } filter_cfg_s;

    typedef struct packed {
        logic [2:0] second_post_divider_code;
        logic       second_realign_enable;
        logic       second_power_down;
    } second_cfg_s;

    ////////////////////////////////////////////////////////////////////////////////
    // code to value conversions
    function automatic logic [8:0] cap_one_pf(input logic [2:0] code);
        cap_one_pf = CAP_ONE_BASE_PF + 9'(CAP_ONE_STEP_PF * {6'h00, code});
    endfunction : cap_one_pf

    function automatic logic [5:0] cap_three_pf(input logic [2:0] code);
        cap_three_pf = 6'(CAP_THREE_STEP_PF * {3'h0, code});
    endfunction : cap_three_pf

    // codes 0 and 1 both give two, above that code plus one
    function automatic logic [3:0] post_div_ratio(input logic [2:0] code);
        post_div_ratio = (code < 3'h2) ? 4'h2 : ({1'b0, code} + 4'h1);
    endfunction : post_div_ratio

endpackage : synth_regs_pkg

// file: rtl/synth2_cal_seq.sv
// enable and calibration sequencer of the second synthesizer
`timescale 1ns/1ps
`default_nettype none
module synth2_cal_seq
    import synth_regs_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // control
    input  wire logic power_down_i,
    // status
    output var  logic enable_o,
    output var  logic cal_reset_o,
    output var  logic cal_busy_o,
    output var  logic cal_done_o
);

    typedef enum logic [2:0] {
        ST_OFF   = 3'b001,
        ST_CAL   = 3'b010,
        ST_READY = 3'b100
    } cal_state_e;

    cal_state_e           state;
    cal_state_e           next_state;
    logic [CAL_CNT_W-1:0] cal_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // next state; power down wins over any progress
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_OFF:   if (!power_down_i) next_state = ST_CAL;
            ST_CAL:   if (power_down_i) next_state = ST_OFF;
                      else if (cal_cnt == CAL_CNT_W'(1)) next_state = ST_READY;
            ST_READY: if (power_down_i) next_state = ST_OFF;
        endcase
    end

    // calibration starts right out of reset, power down bit resets to zero
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state <= ST_CAL;
        else
            state <= next_state;
    end

    // calibration length counter, reloaded on every entry to calibration
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cal_cnt <= CAL_CNT_W'(CAL_CYCLES);
        else if (state != ST_CAL)
            cal_cnt <= CAL_CNT_W'(CAL_CYCLES);
        else if (cal_cnt != '0)
            cal_cnt <= cal_cnt - CAL_CNT_W'(1);
    end

    // outputs registered from the next state so they line up with it
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            enable_o    <= 1'b1;
            cal_reset_o <= 1'b0;
            cal_busy_o  <= 1'b1;
            cal_done_o  <= 1'b0;
        end
        else
        begin
            enable_o    <= (next_state != ST_OFF);
            cal_reset_o <= (next_state == ST_OFF);
            cal_busy_o  <= (next_state == ST_CAL);
            cal_done_o  <= (next_state == ST_READY);
        end
    end

endmodule : synth2_cal_seq
`default_nettype wire

// file: rtl/synth2_realign.sv
// channel realign gating of outputs fed by the second synthesizer
`timescale 1ns/1ps
`default_nettype none
module synth2_realign
    import synth_regs_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // control
    input  wire logic       realign_en_i,
    input  wire logic       sync_event_i,
    // result
    output var  logic       realign_o,
    output var  logic [7:0] realign_count_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // one pulse per accepted event toward every channel on this source
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            realign_o <= 1'b0;
        else
            realign_o <= realign_en_i & sync_event_i;
    end

    // wrapping count of realigns, lets software see events took effect
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            realign_count_o <= 8'h00;
        else if (realign_en_i && sync_event_i)
            realign_count_o <= realign_count_o + 8'h01;
    end

endmodule : synth2_realign
`default_nettype wire

// file: rtl/synth_filter_postdiv_regs.sv
// apb register slice for loop filter codes and second synthesizer control
//
// Function
// - three-bit C1 code, reset zero; capacitance is 5 pF plus 50 pF per step.
// - six-bit R3 code in bits six to one, reset zero, selects filter resistance.
// - three-bit C3 code, reset zero; capacitance is 5 pF per step.
// - post-divider code resets to seven; codes 0,1 divide by 2, others code plus one.
// - realign enable, reset one, lets a sync event resync second-source channels.
// - power-down set disables the second synthesizer and holds calibration in reset.
// - power-down at zero after hardware reset enables and calibrates automatically.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module synth_filter_postdiv_regs
    import synth_regs_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output var  logic [31:0]       prdata_o,
    output var  logic              pready_o,
    output var  logic              pslverr_o,
    // realign event from the output section
    input  wire logic              sync_event_i,
    // first synthesizer loop filter
    output var  filter_cfg_s       filter_cfg_o,
    output var  logic [8:0]        cap_one_pf_o,
    output var  logic [5:0]        cap_three_pf_o,
    // second synthesizer
    output var  second_cfg_s       second_cfg_o,
    output var  logic [3:0]        post_divide_ratio_o,
    output var  logic              second_enable_o,
    output var  logic              second_cal_reset_o,
    output var  logic              second_cal_busy_o,
    output var  logic              second_cal_done_o,
    output var  logic              second_realign_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    typedef enum logic [4:0] {
        SEL_NONE   = 5'b00000,
        SEL_CAP_C1 = 5'b00001,
        SEL_RES_R3 = 5'b00010,
        SEL_CAP_C3 = 5'b00100,
        SEL_CTRL   = 5'b01000,
        SEL_STATUS = 5'b10000
    } reg_sel_e;

    // word aligned only; misaligned addresses fall to unmapped
    function automatic reg_sel_e decode_sel(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0)
        begin
            unique case (addr[ADDR_W-1:2])
                IDX_FILTER_CAP_C1:  sel = SEL_CAP_C1;
                IDX_FILTER_RES_R3:  sel = SEL_RES_R3;
                IDX_FILTER_CAP_C3:  sel = SEL_CAP_C3;
                IDX_SYNTH2_CONTROL: sel = SEL_CTRL;
                IDX_SYNTH2_STATUS:  sel = SEL_STATUS;
                default:            sel = SEL_NONE;
            endcase
        end
        decode_sel = sel;
    endfunction : decode_sel

    ////////////////////////////////////////////////////////////////////////////////
    // internal signals

    reg_sel_e   sel;
    logic       access;
    logic       wr_fire;
    logic       rd_take;
    logic [7:0] wbyte;
    logic [7:0] realign_count;
    logic       cal_enable;
    logic       cal_reset;
    logic       cal_busy;
    logic       cal_done;
    logic       realign_pulse;
    logic [7:0] next_rdata;

    // decode is shared by the read path and the write path
    assign sel    = decode_sel(paddr_i);
    assign access = psel_i & penable_i;
    assign wbyte  = pwdata_i[7:0];

    // one wait state: the write lands on the edge that also sees pready
    assign wr_fire = access & pready_o & pwrite_i & pstrb_i[0];
    assign rd_take = access & ~pready_o;

    ////////////////////////////////////////////////////////////////////////////////
    // apb handshake

    // pready pulses for one cycle in the second access cycle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pready_o <= 1'b0;
        else
            pready_o <= rd_take;
    end

    // error only for unmapped addresses; status writes are silently dropped
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pslverr_o <= 1'b0;
        else
            pslverr_o <= rd_take & (sel == SEL_NONE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux; reserved bits and upper lanes read as zero, except the realign count in status bits 15 to 8

    always_comb
    begin
        next_rdata = 8'h00;
        unique case (sel)
            SEL_CAP_C1:
                next_rdata[CAP_ONE_LSB +: 3] = filter_cfg_o.first_filter_cap_one_code;
            SEL_RES_R3:
            begin
                next_rdata[RES_THREE_LSB +: 6] = filter_cfg_o.first_filter_res_three_code;
                next_rdata[TYPE_SEL_BIT]       = filter_cfg_o.first_filter_type_select;
            end
            SEL_CAP_C3:
                next_rdata[CAP_THREE_LSB +: 3] = filter_cfg_o.first_filter_cap_three_code;
            SEL_CTRL:
            begin
                next_rdata[POST_DIV_LSB +: 3]  = second_cfg_o.second_post_divider_code;
                next_rdata[REALIGN_EN_BIT]     = second_cfg_o.second_realign_enable;
                next_rdata[POWER_DOWN_BIT]     = second_cfg_o.second_power_down;
            end
            SEL_STATUS:
            begin
                next_rdata[ST_ENABLE_BIT]      = cal_enable;
                next_rdata[ST_BUSY_BIT]        = cal_busy;
                next_rdata[ST_DONE_BIT]        = cal_done;
            end
            SEL_NONE:
                next_rdata = 8'h00;
        endcase
    end

    // read data sampled in the first access cycle, zero outside a read answer
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prdata_o <= 32'h0000_0000;
        else if (rd_take && !pwrite_i && sel == SEL_STATUS)
            prdata_o <= {16'h0000, realign_count, next_rdata};
        else if (rd_take && !pwrite_i)
            prdata_o <= {24'h00_0000, next_rdata};
        else
            prdata_o <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // first synthesizer loop filter registers

    // C1 code, scaled downstream as base plus fixed steps
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            filter_cfg_o.first_filter_cap_one_code <= RST_CAP_ONE;
        else if (wr_fire && sel == SEL_CAP_C1)
            filter_cfg_o.first_filter_cap_one_code <= wbyte[CAP_ONE_LSB +: 3];
    end

    // R3 code and the integer or fractional filter type share one byte
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            filter_cfg_o.first_filter_res_three_code <= RST_RES_THREE;
            filter_cfg_o.first_filter_type_select    <= RST_TYPE_SEL;
        end
        else if (wr_fire && sel == SEL_RES_R3)
        begin
            filter_cfg_o.first_filter_res_three_code <= wbyte[RES_THREE_LSB +: 6];
            filter_cfg_o.first_filter_type_select    <= wbyte[TYPE_SEL_BIT];
        end
    end

    // C3 code, pure multiple of the step
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            filter_cfg_o.first_filter_cap_three_code <= RST_CAP_THREE;
        else if (wr_fire && sel == SEL_CAP_C3)
            filter_cfg_o.first_filter_cap_three_code <= wbyte[CAP_THREE_LSB +: 3];
    end

    // capacitance values follow the codes one cycle later
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cap_one_pf_o   <= cap_one_pf(RST_CAP_ONE);
            cap_three_pf_o <= cap_three_pf(RST_CAP_THREE);
        end
        else
        begin
            cap_one_pf_o   <= cap_one_pf(filter_cfg_o.first_filter_cap_one_code);
            cap_three_pf_o <= cap_three_pf(filter_cfg_o.first_filter_cap_three_code);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // second synthesizer control register

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            second_cfg_o.second_post_divider_code <= RST_POST_DIV;
            second_cfg_o.second_realign_enable    <= RST_REALIGN_EN;
            second_cfg_o.second_power_down        <= RST_POWER_DOWN;
        end
        else if (wr_fire && sel == SEL_CTRL)
        begin
            second_cfg_o.second_post_divider_code <= wbyte[POST_DIV_LSB +: 3];
            second_cfg_o.second_realign_enable    <= wbyte[REALIGN_EN_BIT];
            second_cfg_o.second_power_down        <= wbyte[POWER_DOWN_BIT];
        end
    end

    // divide ratio decoded once here so the divider sees a plain number
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            post_divide_ratio_o <= post_div_ratio(RST_POST_DIV);
        else
            post_divide_ratio_o <= post_div_ratio(second_cfg_o.second_post_divider_code);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // enable and calibration sequencing

    // a clear of power down restarts the whole calibration, not a resume
    synth2_cal_seq u_cal_seq (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .power_down_i (second_cfg_o.second_power_down),
        .enable_o     (cal_enable),
        .cal_reset_o  (cal_reset),
        .cal_busy_o   (cal_busy),
        .cal_done_o   (cal_done)
    );

    // outputs re-registered so every top output leaves from a local flop
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            second_enable_o    <= 1'b0;
            second_cal_reset_o <= 1'b1;
            second_cal_busy_o  <= 1'b0;
            second_cal_done_o  <= 1'b0;
        end
        else
        begin
            second_enable_o    <= cal_enable;
            second_cal_reset_o <= cal_reset;
            second_cal_busy_o  <= cal_busy;
            second_cal_done_o  <= cal_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel realign

    synth2_realign u_realign (
        .clk_i           (clk_i),
        .rst_b_i         (rst_b_i),
        .realign_en_i    (second_cfg_o.second_realign_enable),
        .sync_event_i    (sync_event_i),
        .realign_o       (realign_pulse),
        .realign_count_o (realign_count)
    );

    // a powered-down source has no running channels to realign
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            second_realign_o <= 1'b0;
        else
            second_realign_o <= realign_pulse & cal_enable;
    end

endmodule : synth_filter_postdiv_regs
`default_nettype wire

// file: test/synth_regs_properties.sv
// timing and decode properties of the synthesizer register slice
`timescale 1ns/1ps
`default_nettype none
module synth_regs_props
    import synth_regs_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // bus and event inputs
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        sync_event_i,
    // observed outputs
    input  wire logic        pready_o,
    input  wire filter_cfg_s filter_cfg_o,
    input  wire logic [8:0]  cap_one_pf_o,
    input  wire logic [5:0]  cap_three_pf_o,
    input  wire second_cfg_s second_cfg_o,
    input  wire logic [3:0]  post_divide_ratio_o,
    input  wire logic        second_enable_o,
    input  wire logic        second_cal_reset_o,
    input  wire logic        second_cal_busy_o,
    input  wire logic        second_cal_done_o,
    input  wire logic        second_realign_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////
    // bus handshake: one wait state, one-cycle answer
    AST_ONE_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer one cycle after access");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready stood longer than a cycle");
    // analog values follow the stored codes one cycle later
    AST_CAP_ONE: assert property (cap_one_pf_o == 9'h005 + 9'h032 *
        {6'h00, $past(filter_cfg_o.first_filter_cap_one_code)}) else $error("c1 value wrong");
    AST_CAP_THREE: assert property (cap_three_pf_o == 6'h05 *
        {3'h0, $past(filter_cfg_o.first_filter_cap_three_code)}) else $error("c3 value wrong");
    AST_POST_DIV: assert property (post_divide_ratio_o ==
        (($past(second_cfg_o.second_post_divider_code) < 3'h2) ? 4'h2 :
        {1'b0, $past(second_cfg_o.second_post_divider_code)} + 4'h1))
        else $error("post divide ratio wrong");
    // power-down stops the synthesizer; clearing it restarts calibration
    AST_PD_OFF: assert property (second_cfg_o.second_power_down |-> ##2
        (!second_enable_o && second_cal_reset_o)) else $error("power-down not honoured");
    AST_PD_RESTART: assert property ($fell(second_cfg_o.second_power_down)
        |-> ##[1:3] second_cal_busy_o) else $error("calibration did not restart");
    AST_DONE_ENABLED: assert property (second_cal_done_o |->
        (second_enable_o && !second_cal_busy_o)) else $error("done while disabled");
    // realign pulse comes two cycles after an enabled event, never uncaused
    AST_REALIGN: assert property (sync_event_i && second_enable_o &&
        second_cfg_o.second_realign_enable |-> ##2 second_realign_o) else $error("no realign");
    AST_REALIGN_CAUSE: assert property (second_realign_o |-> $past(sync_event_i, 2))
        else $error("realign without event");

    COV_PD: cover property ($fell(second_cfg_o.second_power_down));
    COV_REALIGN: cover property (second_realign_o);
    COV_DONE: cover property ($rose(second_cal_done_o));
endmodule : synth_regs_props

bind synth_filter_postdiv_regs synth_regs_props u_synth_regs_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .sync_event_i(sync_event_i), .pready_o(pready_o), .filter_cfg_o(filter_cfg_o),
    .cap_one_pf_o(cap_one_pf_o), .cap_three_pf_o(cap_three_pf_o),
    .second_cfg_o(second_cfg_o), .post_divide_ratio_o(post_divide_ratio_o),
    .second_enable_o(second_enable_o), .second_cal_reset_o(second_cal_reset_o),
    .second_cal_busy_o(second_cal_busy_o), .second_cal_done_o(second_cal_done_o),
    .second_realign_o(second_realign_o));
`default_nettype wire

// file: test/tb_top.sv
// self-checking bench of the synthesizer register slice
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import synth_regs_pkg::*;
;
    logic        clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic        sync_event_i = 0, pslverr_o, pready_o, second_realign_o;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic [3:0]  pstrb_i = 4'hf, post_divide_ratio_o;
    logic [8:0]  cap_one_pf_o;
    logic [5:0]  cap_three_pf_o;
    logic        second_enable_o, second_cal_reset_o, second_cal_busy_o, second_cal_done_o;
    logic        er;
    filter_cfg_s filter_cfg_o;
    second_cfg_s second_cfg_o;
    int          fail_count = 0, cmp_count = 0, n;
    logic [11:0] adr [4];
    logic [31:0] rstv [4], msk [4];

    synth_filter_postdiv_regs u_synth_filter_postdiv_regs (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .sync_event_i(sync_event_i), .filter_cfg_o(filter_cfg_o),
        .cap_one_pf_o(cap_one_pf_o), .cap_three_pf_o(cap_three_pf_o),
        .second_cfg_o(second_cfg_o), .post_divide_ratio_o(post_divide_ratio_o),
        .second_enable_o(second_enable_o), .second_cal_reset_o(second_cal_reset_o),
        .second_cal_busy_o(second_cal_busy_o), .second_cal_done_o(second_cal_done_o),
        .second_realign_o(second_realign_o));

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////
    task automatic tally_and_finish;
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    // one apb transfer; the request holds until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (k >= 20)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask : apb

    // wait for a status level, bounded; counts cycles spent in n
    task automatic wait_for(input logic want_done);
        n = 0;
        while (((want_done ? second_cal_done_o : second_cal_busy_o) !== 1'b1) && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 400)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask : wait_for

    // one event pulse, then count realign pulses seen
    task automatic sync_pulse(output int c);
        c = 0;
        @(posedge clk_i);
        sync_event_i <= 1'b1;
        @(posedge clk_i);
        sync_event_i <= 1'b0;
        repeat (5) @(posedge clk_i) c += int'(second_realign_o === 1'b1);
    endtask : sync_pulse

    ////////////////////////////////////////
    initial
    begin
        adr = '{12'h110, 12'h114, 12'h118, 12'h11c};
        rstv = '{32'h0, 32'h0, 32'h0, 32'h1e};
        msk = '{32'h07, 32'h7f, 32'h07, 32'h1f};
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // power-down clear at reset: calibrates on its own
        wait_for(1'b1);
        chk(second_enable_o, 1);
        for (int i = 0; i < 4; i++)
        begin
            apb(0, adr[i], 0);
            chk(rd, rstv[i]);
            apb(1, adr[i], 32'hff);
            apb(0, adr[i], 0);
            chk(rd, msk[i]);
        end
        repeat (3) @(posedge clk_i);
        chk(filter_cfg_o, 32'h1fff);
        chk(cap_one_pf_o, 32'd355);
        chk(cap_three_pf_o, 32'd35);
        chk({second_enable_o, second_cal_reset_o}, 2'b01);
        // clearing power-down restarts the full calibration
        apb(1, 12'h11c, 32'h1e);
        wait_for(1'b0);
        wait_for(1'b1);
        chk(32'(n >= CAL_CYCLES - 1 && n <= CAL_CYCLES + 1), 1);
        // every post-divider code, back to back
        for (int c = 0; c < 8; c++)
        begin
            apb(1, 12'h11c, {27'h0, 3'(c), 2'b10});
            repeat (2) @(posedge clk_i);
            chk(post_divide_ratio_o, (c < 2) ? 2 : c + 1);
        end
        sync_pulse(n);
        chk(n, 1);
        apb(1, 12'h11c, 32'h1c);
        sync_pulse(n);
        chk(n, 0);
        // status: enabled, calibrated, one realign counted
        apb(0, 12'h120, 0);
        chk(rd, 32'h0000_0105);
        // lane 0 strobe off leaves the code alone; unmapped place errors
        pstrb_i <= 4'he;
        apb(1, 12'h110, 32'h02);
        pstrb_i <= 4'hf;
        apb(0, 12'h110, 0);
        chk(rd, 32'h07);
        apb(0, 12'h200, 0);
        chk(rd, 32'h0);
        chk(er, 1);
        // mid-run hardware reset clears a stored power-down and recalibrates
        apb(1, 12'h11c, 32'h1d);
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({second_enable_o, second_cal_reset_o}, 2'b01);
        rst_b_i <= 1'b1;
        wait_for(1'b1);
        chk(second_enable_o, 1);
        apb(0, 12'h11c, 0);
        chk(rd, 32'h1e);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
